// [sgpa_pkg.sv]
// Purpose: Constants for the serializer sideband GPIO and audio block.
// Assumes: Byte-wide registers reached through a simple register port.
// Notes:   Config nibble codes select input, output, high or low.
package sgpa_pkg;
  localparam logic [7:0] LINE0_CONFIG_ADDR       = 8'h0d;
  localparam logic [7:0] LINE1_LINE2_CONFIG_ADDR = 8'h0e;
  localparam logic [7:0] LINE3_OUT4_CONFIG_ADDR  = 8'h0f;
  localparam logic [7:0] OUT5_OUT6_CONFIG_ADDR   = 8'h10;
  localparam logic [7:0] OUT7_OUT8_CONFIG_ADDR   = 8'h11;
  localparam logic [7:0] COLOUR_MODE_CONFIG_ADDR = 8'h12;
  localparam logic [7:0] REG_RESET               = 8'h00;
  localparam logic [7:0] MODE18_VALUE            = 8'h04;
  localparam int         MODE18_BIT              = 2;
  localparam int         SEC_AUDIO_BIT           = 0;
  localparam logic [7:0] LINE0_FWD               = 8'h93;
  localparam logic [7:0] LINE0_BACK              = 8'h95;
  localparam logic [3:0] NIB_FWD                 = 4'h3;
  localparam logic [3:0] NIB_BACK                = 4'h5;
  localparam logic [3:0] NIB_HIGH                = 4'h9;
  localparam logic [3:0] NIB_LOW                 = 4'h1;
  localparam int         PCLK_HZ                 = 25000000;
  localparam int         AUDIO_CLK_MAX_HZ        = 12288000;
  localparam int         AUDIO_RATE_DIV          = 4;
  localparam int         LINE_COUNT              = 4;
  localparam int         OUT_COUNT               = 5;
  localparam int         AUDIO_LINES             = 4;
  typedef enum logic [1:0] {SGPA_OFF, SGPA_FWD, SGPA_BACK} sgpa_dir_e;
endpackage : sgpa_pkg

// [sgpa_sideband.sv]
// Purpose: Sideband GPIO, register-driven outputs and audio input sampling.
// Assumes: Register port and link data are in the pixel clock domain.
// Notes:   Audio pins and strap come from outside and are synchronised.
`timescale 1ns/1ps
`default_nettype none
// How it works
// (RL1) In 18-bit mode the four low colour inputs become configurable lines.
// (RL2) Writing 0x04 to register colour_mode_config enables 18-bit mode.
// (RL3) Line 3 uses low nibble of line3_out4_config: 3 forward, 5 back.
// (RL4) Line 2 uses high nibble of line1_line2_config: 3 forward, 5 back.
// (RL5) Line 1 uses low nibble of line1_line2_config: 3 forward, 5 back.
// (RL6) Line 0 uses register line0_config: 0x93 forward, 0x95 back.
// (RL7) Outputs 8 to 4 are driven only from register bits in 18-bit mode.
// (RL8) Output 8 uses high nibble of out7_out8_config: 9 high, 1 low.
// (RL9) Output 7 uses low nibble of out7_out8_config: 9 high, 1 low.
// (RL10) Output 6 uses high nibble of out5_out6_config: 9 high, 1 low.
// (RL11) Output 5 uses low nibble of out5_out6_config: 9 high, 1 low.
// (RL12) Output 4 uses high nibble of line3_out4_config: 9 high, 1 low.
// (RL13) In 24-bit mode clock, word select and data audio lines are carried.
// (RL14) Audio source keeps bit rate at or below a quarter pixel clock.
// (RL15) Secondary data is clocked by and aligned to the audio bit clock.
// (RL16) Secondary audio is enabled by strap input or register colour_mode_config bit 0.
// (RL17) Audio bit clocks up to 12.288 MHz are accepted.
// (RL18) Secondary audio forces 18-bit mode and enables the secondary input.
// (RL19) In 24-bit mode colour inputs stay video; line nibbles are ignored.
module sgpa_sideband #(
  parameter int LINES = sgpa_pkg::LINE_COUNT,
  parameter int OUTS  = sgpa_pkg::OUT_COUNT
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             regWrite,
  input  wire logic             regRead,
  input  wire logic [7:0]       regAddr,
  input  wire logic [7:0]       regWdata,
  output logic      [7:0]       regRdata,
  input  wire logic [LINES-1:0] colourLow,
  output logic      [LINES-1:0] videoLow,
  output logic      [LINES-1:0] fwdLineData,
  output logic      [LINES-1:0] fwdLineValid,
  input  wire logic [LINES-1:0] backLineData,
  output logic      [LINES-1:0] lineOut,
  output logic      [LINES-1:0] lineOutEn,
  output logic      [OUTS-1:0]  register_driven_outputs,
  input  wire logic             secAudioStrap,
  input  wire logic             audioBitClock,
  input  wire logic             audio_word_select,
  input  wire logic             audio_primary_data,
  input  wire logic             audio_secondary_data,
  output logic                  audioSampleValid,
  output logic      [3:0]       audioSample,
  output logic                  mode18,
  output logic                  secAudioOn
);
  import sgpa_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] line0Cfg;
  logic [7:0] line12Cfg;
  logic [7:0] line3Out4Cfg;
  logic [7:0] out56Cfg;
  logic [7:0] out78Cfg;
  logic [7:0] modeCfg;

  function automatic logic addrHit(input logic       strobe,
                                   input logic [7:0] addr,
                                   input logic [7:0] target);
    return strobe && (addr == target);
  endfunction : addrHit

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      line0Cfg <= REG_RESET;
    end else if (addrHit(regWrite, regAddr, LINE0_CONFIG_ADDR)) begin
      line0Cfg <= regWdata; // RL6
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      line12Cfg <= REG_RESET;
    end else if (addrHit(regWrite, regAddr, LINE1_LINE2_CONFIG_ADDR)) begin
      line12Cfg <= regWdata; // RL4 RL5
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      line3Out4Cfg <= REG_RESET;
    end else if (addrHit(regWrite, regAddr, LINE3_OUT4_CONFIG_ADDR)) begin
      line3Out4Cfg <= regWdata; // RL3 RL12
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out56Cfg <= REG_RESET;
    end else if (addrHit(regWrite, regAddr, OUT5_OUT6_CONFIG_ADDR)) begin
      out56Cfg <= regWdata; // RL10 RL11
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out78Cfg <= REG_RESET;
    end else if (addrHit(regWrite, regAddr, OUT7_OUT8_CONFIG_ADDR)) begin
      out78Cfg <= regWdata; // RL8 RL9
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      modeCfg <= REG_RESET;
    end else if (addrHit(regWrite, regAddr, COLOUR_MODE_CONFIG_ADDR)) begin
      modeCfg <= regWdata; // RL2 RL16
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= REG_RESET;
    end else if (regRead) begin
      unique case (regAddr)
        LINE0_CONFIG_ADDR:       regRdata <= line0Cfg;
        LINE1_LINE2_CONFIG_ADDR: regRdata <= line12Cfg;
        LINE3_OUT4_CONFIG_ADDR:  regRdata <= line3Out4Cfg;
        OUT5_OUT6_CONFIG_ADDR:   regRdata <= out56Cfg;
        OUT7_OUT8_CONFIG_ADDR:   regRdata <= out78Cfg;
        COLOUR_MODE_CONFIG_ADDR: regRdata <= modeCfg;
        default:                 regRdata <= REG_RESET;
      endcase
    end
  end

  // ****************************************
  // Strap and mode
  // ****************************************
  logic strapMeta;
  logic strapSync;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strapMeta <= 1'b0;
      strapSync <= 1'b0;
    end else begin
      strapMeta <= secAudioStrap;
      strapSync <= strapMeta;
    end
  end

  logic next_secAudio;
  logic next_mode18;
  assign next_secAudio = strapSync | modeCfg[SEC_AUDIO_BIT]; // RL16
  assign next_mode18 = modeCfg[MODE18_BIT] | next_secAudio; // RL2 RL18

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode18 <= 1'b0;
    end else begin
      mode18 <= next_mode18; // RL2 RL18
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      secAudioOn <= 1'b0;
    end else begin
      secAudioOn <= next_secAudio; // RL16
    end
  end

  // ****************************************
  // General lines
  // ****************************************
  function automatic sgpa_dir_e nibDir(input logic [3:0] nib);
    if (nib == NIB_FWD) begin
      return SGPA_FWD;
    end else if (nib == NIB_BACK) begin
      return SGPA_BACK;
    end
    return SGPA_OFF;
  endfunction : nibDir

  function automatic logic nibLevel(input logic [3:0] nib,
                                    input logic       prev);
    if (nib == NIB_HIGH) begin
      return 1'b1;
    end else if (nib == NIB_LOW) begin
      return 1'b0;
    end
    return prev;
  endfunction : nibLevel

  sgpa_dir_e lineDir [LINES];
  always_comb begin
    lineDir[0] = (line0Cfg == LINE0_FWD) ? SGPA_FWD :
                 (line0Cfg == LINE0_BACK) ? SGPA_BACK : SGPA_OFF; // RL6
    lineDir[1] = nibDir(line12Cfg[3:0]); // RL5
    lineDir[2] = nibDir(line12Cfg[7:4]); // RL4
    lineDir[3] = nibDir(line3Out4Cfg[3:0]); // RL3
  end

  logic [LINES-1:0] lineFwd;
  logic [LINES-1:0] lineBack;
  always_comb begin
    for (int i = 0; i < LINES; i++) begin
      lineFwd[i]  = mode18 && (lineDir[i] == SGPA_FWD); // RL1
      lineBack[i] = mode18 && (lineDir[i] == SGPA_BACK); // RL1 RL19
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      videoLow <= '0;
    end else begin
      videoLow <= mode18 ? '0 : colourLow; // RL19
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fwdLineValid <= '0;
    end else begin
      fwdLineValid <= lineFwd; // RL1
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fwdLineData <= '0;
    end else begin
      fwdLineData <= colourLow & lineFwd; // RL1
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lineOutEn <= '0;
    end else begin
      lineOutEn <= lineBack; // RL1
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lineOut <= '0;
    end else begin
      lineOut <= backLineData & lineBack; // RL1
    end
  end

  // ****************************************
  // Register-driven outputs
  // ****************************************
  logic [3:0] outNib [OUTS];
  always_comb begin
    outNib[0] = line3Out4Cfg[7:4]; // RL12
    outNib[1] = out56Cfg[3:0]; // RL11
    outNib[2] = out56Cfg[7:4]; // RL10
    outNib[3] = out78Cfg[3:0]; // RL9
    outNib[4] = out78Cfg[7:4]; // RL8
  end

  logic [OUTS-1:0] outLevel;
  logic [OUTS-1:0] next_outLevel;
  always_comb begin
    for (int i = 0; i < OUTS; i++) begin
      next_outLevel[i] = nibLevel(outNib[i], outLevel[i]);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      outLevel <= '0;
    end else begin
      outLevel <= next_outLevel;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      register_driven_outputs <= '0;
    end else begin
      register_driven_outputs <= mode18 ? next_outLevel : '0; // RL7
    end
  end

  // ****************************************
  // Audio input
  // ****************************************
  logic [3:0] audioMeta;
  logic [3:0] audioSync;
  logic       bitClkPrev;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      audioMeta  <= '0;
      audioSync  <= '0;
      bitClkPrev <= 1'b0;
    end else begin
      audioMeta  <= {audio_secondary_data, audio_primary_data,
                     audio_word_select, audioBitClock};
      audioSync  <= audioMeta;
      bitClkPrev <= audioSync[0];
    end
  end

  // Bit clock at or below a quarter of the pixel clock keeps edges visible.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      audioSampleValid <= 1'b0;
      audioSample      <= '0;
    end else begin
      audioSampleValid <= audioSync[0] & ~bitClkPrev; // RL13 RL14 RL17
      if (audioSync[0] & ~bitClkPrev) begin
        audioSample <= {audioSync[3] & secAudioOn, audioSync[2],
                        audioSync[1], 1'b1}; // RL15 RL18
      end
    end
  end
endmodule : sgpa_sideband
`default_nettype wire

// [sgpa_chk.sv]
// Purpose: Port checks for the sideband block.
// Assumes: One clock, async low reset.
// Notes: Bound from tb.
`timescale 1ns/1ps
`default_nettype none
module sgpa_chk #(parameter int LINES = 4, parameter int OUTS = 5) (
  input wire logic             clock,
  input wire logic             rst_n,
  input wire logic             regWrite,
  input wire logic [7:0]       regAddr,
  input wire logic [7:0]       regWdata,
  input wire logic [LINES-1:0] colourLow,
  input wire logic [LINES-1:0] videoLow,
  input wire logic [LINES-1:0] fwdLineData,
  input wire logic [LINES-1:0] fwdLineValid,
  input wire logic [LINES-1:0] backLineData,
  input wire logic [LINES-1:0] lineOut,
  input wire logic [LINES-1:0] lineOutEn,
  input wire logic [OUTS-1:0]  register_driven_outputs,
  input wire logic             audioSampleValid,
  input wire logic [3:0]       audioSample,
  input wire logic             mode18,
  input wire logic             secAudioOn
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic wr;
  assign wr = regWrite && mode18;
  a_mode_enter: assert property ((regWrite && regAddr == 8'h12 &&
    regWdata == 8'h04) |-> ##2 mode18) else $error("mode late");
  a_video_off: assert property (mode18 && $past(mode18) |->
    videoLow == 0) else $error("video in 18");
  a_video_pass: assert property ($past(rst_n) && !mode18 &&
    !$past(mode18) |-> videoLow == $past(colourLow) &&
    fwdLineValid == 0 && lineOutEn == 0) else $error("24 lines");
  a_fwd_data: assert property ((fwdLineValid &
    (fwdLineData ^ $past(colourLow))) == 0) else $error("fwd data");
  a_back_data: assert property ((lineOutEn &
    (lineOut ^ $past(backLineData))) == 0) else $error("back data");
  a_dir_excl: assert property ((fwdLineValid & lineOutEn) == 0)
    else $error("both dirs");
  a_line3_fwd: assert property (wr && regAddr == 8'h0f &&
    regWdata[3:0] == 4'h3 |-> ##2 fwdLineValid[3]) else $error("ln3");
  a_out8_high: assert property (wr && regAddr == 8'h11 &&
    regWdata[7:4] == 4'h9 |-> ##[1:2] register_driven_outputs[4])
    else $error("out8");
  a_sample_pulse: assert property (audioSampleValid |=>
    !audioSampleValid) else $error("pulse");
  a_sec_gate: assert property (audioSampleValid && !secAudioOn &&
    !$past(secAudioOn) |-> audioSample[3] == 1'b0) else $error("sec");
  c_back: cover property (mode18 && lineOutEn != 0);
  c_outs: cover property (register_driven_outputs != 0);
  c_sec: cover property (audioSampleValid && secAudioOn);
endmodule : sgpa_chk
`default_nettype wire

// [sgpa_partner.sv]
// Purpose: Audio source and back-channel model.
// Assumes: Bit clock is one eighth of the pixel clock.
// Notes: Data changes at one bit clock phase.
`timescale 1ns/1ps
`default_nettype none
module sgpa_partner (
  input  wire logic clock,
  output logic      audioBitClock = 1'b0,
  output logic      audio_word_select = 1'b0,
  output logic      audio_primary_data = 1'b0,
  output logic      audio_secondary_data = 1'b0,
  output logic [3:0] backLineData = 4'h0
);
  logic [7:0] cnt = 8'h00;
  always_ff @(posedge clock) begin
    cnt <= cnt + 8'h01;
    backLineData <= cnt[3:0] ^ 4'h6;
    audioBitClock <= cnt[2];
    if (cnt[2:0] == 3'h7) begin
      audio_primary_data <= cnt[3];
      audio_secondary_data <= ~cnt[4];
      audio_word_select <= cnt[6];
    end
  end
endmodule : sgpa_partner
`default_nettype wire

// [tb.sv]
// Purpose: Register sequence tests of the sideband block.
// Assumes: Outputs settle within three cycles of a write.
// Notes: Partner supplies audio and back-channel data.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic secAudioStrap = 1'b0, audioSampleValid, mode18, secAudioOn;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
  logic [3:0] colourLow = 4'ha, videoLow, fwdLineData, fwdLineValid;
  logic [3:0] backLineData, lineOut, lineOutEn, audioSample;
  logic [4:0] register_driven_outputs;
  logic audioBitClock, audio_word_select;
  logic audio_primary_data, audio_secondary_data;
  int err_count = 0, cmp_count = 0, i, n, k;
  localparam logic [7:0] CFG [3][5] = '{
    '{8'h93, 8'h35, 8'h95, 8'h19, 8'h91},
    '{8'h95, 8'h53, 8'h13, 8'h91, 8'h19},
    '{8'h94, 8'h00, 8'h10, 8'h00, 8'h44}};
  localparam logic [12:0] EXP [3] = '{13'h0b53, 13'h14ac, 13'h000c};
  sgpa_sideband dut (
    .clock                   (clock),
    .rst_n                   (rst_n),
    .regWrite                (regWrite),
    .regRead                 (regRead),
    .regAddr                 (regAddr),
    .regWdata                (regWdata),
    .regRdata                (regRdata),
    .colourLow               (colourLow),
    .videoLow                (videoLow),
    .fwdLineData             (fwdLineData),
    .fwdLineValid            (fwdLineValid),
    .backLineData            (backLineData),
    .lineOut                 (lineOut),
    .lineOutEn               (lineOutEn),
    .register_driven_outputs (register_driven_outputs),
    .secAudioStrap           (secAudioStrap),
    .audioBitClock           (audioBitClock),
    .audio_word_select       (audio_word_select),
    .audio_primary_data      (audio_primary_data),
    .audio_secondary_data    (audio_secondary_data),
    .audioSampleValid        (audioSampleValid),
    .audioSample             (audioSample),
    .mode18                  (mode18),
    .secAudioOn              (secAudioOn)
  );
  sgpa_partner far (
    .clock                (clock),
    .audioBitClock        (audioBitClock),
    .audio_word_select    (audio_word_select),
    .audio_primary_data   (audio_primary_data),
    .audio_secondary_data (audio_secondary_data),
    .backLineData         (backLineData)
  );
  always #20 clock = ~clock;
  task automatic chk(input string s, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    chk("rdata", e, regRdata);
  endtask : rd
  task automatic final_report;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (3000) @(posedge clock);
    err_count++;
    final_report;
  end
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++) rd(8'h0d + i[7:0], 8'h00);
    for (i = 0; i < 5; i++) wr(8'h0d + i[7:0], 8'h93 + i[7:0]);
    wr(8'h20, 8'h55);
    for (i = 0; i < 5; i++) rd(8'h0d + i[7:0], 8'h93 + i[7:0]);
    rd(8'h20, 8'h00);
    chk("video", 8'h0a, {4'h0, videoLow});
    chk("lines", 8'h00, {fwdLineValid, lineOutEn});
    chk("outs", 8'h00, {3'h0, register_driven_outputs});
    wr(8'h12, 8'h04);
    repeat (3) @(negedge clock);
    chk("mode", 8'h01, {7'h0, mode18});
    chk("video", 8'h00, {4'h0, videoLow});
    chk("lines", 8'h18, {fwdLineValid, lineOutEn});
    chk("outs", 8'h15, {3'h0, register_driven_outputs});
    for (i = 0; i < 3; i++) begin
      @(posedge clock);
      colourLow <= i[3:0] ^ 4'h6;
      for (n = 0; n < 5; n++) wr(8'h0d + n[7:0], CFG[i][n]);
      repeat (3) @(negedge clock);
      chk("lines", EXP[i][12:5], {fwdLineValid, lineOutEn});
      chk("outs", {3'h0, EXP[i][4:0]},
        {3'h0, register_driven_outputs});
      chk("fwd", {4'h0, colourLow & EXP[i][12:9]},
        {4'h0, fwdLineData & fwdLineValid});
    end
    wr(8'h12, 8'h01);
    repeat (3) @(negedge clock);
    chk("sec", 8'h03, {6'h0, mode18, secAudioOn});
    n = 0;
    k = 0;
    repeat (80) @(negedge clock) begin
      if (audioSampleValid === 1'b1) n++;
      if (audioSampleValid === 1'b1 && audioSample[3] === 1'b1) k++;
    end
    chk("pulses", 8'h0a, n[7:0]);
    chk("secdata", 8'h01, {7'h0, k > 0});
    wr(8'h12, 8'h00);
    repeat (3) @(negedge clock);
    chk("sec", 8'h00, {6'h0, mode18, secAudioOn});
    k = 0;
    repeat (80) @(negedge clock) begin
      if (audioSampleValid === 1'b1 && audioSample[3] === 1'b1) k++;
    end
    chk("secoff", 8'h00, k[7:0]);
    @(posedge clock);
    secAudioStrap <= 1'b1;
    repeat (6) @(negedge clock);
    chk("strap", 8'h03, {6'h0, mode18, secAudioOn});
    final_report;
  end
endmodule : tb
bind sgpa_sideband sgpa_chk #(
  .LINES (LINES),
  .OUTS  (OUTS)
) chk (
  .clock                   (clock),
  .rst_n                   (rst_n),
  .regWrite                (regWrite),
  .regAddr                 (regAddr),
  .regWdata                (regWdata),
  .colourLow               (colourLow),
  .videoLow                (videoLow),
  .fwdLineData             (fwdLineData),
  .fwdLineValid            (fwdLineValid),
  .backLineData            (backLineData),
  .lineOut                 (lineOut),
  .lineOutEn               (lineOutEn),
  .register_driven_outputs (register_driven_outputs),
  .audioSampleValid        (audioSampleValid),
  .audioSample             (audioSample),
  .mode18                  (mode18),
  .secAudioOn              (secAudioOn)
);
`default_nettype wire
